/* ctp_consts.vh */
// Constants for the transmit process-data scheduler
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CTP_CLK_HZ 25000000
`define CTP_TICK_US 100
`define CTP_TICK_CYC (`CTP_CLK_HZ / 1000000 * `CTP_TICK_US)
`define CTP_EVENT_MS 200
`define CTP_EVENT_DEF 16'd2000
`define CTP_INHIBIT_MS 2
`define CTP_INHIBIT_DEF 16'd20
`define CTP_SDO_TO_MS 1000
`define CTP_SDO_TO_CYC (`CTP_CLK_HZ / 1000 * `CTP_SDO_TO_MS)

// ----------------------------------------
// Transmission types
// ----------------------------------------
`define CTP_TYPE_SYNC_MAX 8'hf0
`define CTP_TYPE_ASYNC_MIN 8'hfe
`define CTP_TYPE_DEF 8'hff

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTP_A_NODE 8'h00
`define CTP_A_STATUS 8'h01
`define CTP_A_SDO_ARG0 8'h02
`define CTP_A_SDO_ARG1 8'h03
`define CTP_A_SDO_GO 8'h04
`define CTP_A_CH_BASE 8'h10
`define CTP_A_DATA_BASE 8'h40
`define CTP_CH_CFG 2'h0
`define CTP_CH_INH 2'h1
`define CTP_CH_EVT 2'h2
`define CTP_CH_LAST 2'h3

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTP_CFG_EN_BIT 24
`define CTP_NODE_DEF 7'h01
`define CTP_ID_BASE_LSB 4'h3

// ----------------------------------------
// Dictionary objects
// ----------------------------------------
`define CTP_OBJ_COMM 16'h1800
`define CTP_OBJ_MAP 16'h1a00
`define CTP_OBJ_USER 16'h2000
`define CTP_SUB_TYPE 8'h02
`define CTP_SUB_INH 8'h03
`define CTP_SUB_EVT 8'h05
`define CTP_SUB_START 8'h06
`define CTP_MAP_BITS 8'h20
`define CTP_SDO_STEPS 3'h7

`endif

/* ctp_channel.v */
// One transmit channel: trigger, inhibit and event timing
`include "ctp_consts.vh"
`default_nettype none

module ctp_channel (
  input wire sys_clk, // System clock
  input wire rst, // Async reset
  input wire tick, // 100 us enable
  input wire syncIn, // SYNC frame seen
  input wire oper, // Node operational
  input wire enable, // Channel enabled
  input wire cfgWr, // Channel configured
  input wire grant, // Frame taken for send
  input wire [7:0] txType, // Transmission type
  input wire [7:0] startSync, // SYNCs to skip first
  input wire [15:0] inhibit, // Least gap, 100 us units
  input wire [15:0] eventTmr, // Refresh period, 100 us units
  input wire [31:0] value, // Mapped register
  output wire due, // Frame wanted now
  output reg [31:0] lastSent // Value last sent
);

  reg operPrev;
  reg pend;
  reg syncDue;
  reg [15:0] inhCnt;
  reg [15:0] evtCnt;
  reg [7:0] syncCnt;
  reg [7:0] startCnt;

  wire isAsync = txType >= `CTP_TYPE_ASYNC_MIN;
  wire isSync = txType <= `CTP_TYPE_SYNC_MAX;
  wire changed = value != lastSent;
  wire opRise = oper & ~operPrev;
  wire evtFire = tick & (eventTmr != 16'h0) & (evtCnt == 16'h1); // [RULE9]
  wire syncOpen = syncIn & isSync & (startCnt == 8'h0); // [RULE11]
  wire cycHit = (txType == 8'h0) ? changed : (syncCnt + 8'h1 >= txType); // [RULE7]
  wire syncHit = syncOpen & (cycHit | pend | changed); // [RULE10]

  assign due = enable & oper & (inhCnt == 16'h0) & (isAsync ? (pend | changed) : syncDue); // [RULE4] [RULE8] [RULE17]

  // ----------------------------------------
  // Triggers
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      operPrev <= 1'b0;
      pend <= 1'b0;
      syncDue <= 1'b0;
      syncCnt <= 8'h0;
      startCnt <= 8'h0;
      lastSent <= 32'h0;
    end else begin
      operPrev <= oper;
      if (!oper) begin
        pend <= 1'b0;
        syncDue <= 1'b0;
      end else begin
        if ((isAsync & (opRise | cfgWr)) | evtFire)
          pend <= 1'b1; // [RULE3] [RULE5]
        else if (grant)
          pend <= 1'b0;
        if (syncHit)
          syncDue <= 1'b1; // [RULE10]
        else if (grant)
          syncDue <= 1'b0;
      end
      if (cfgWr | opRise) begin
        startCnt <= startSync; // [RULE11]
        syncCnt <= 8'h0;
      end else if (syncIn & isSync) begin
        if (startCnt != 8'h0)
          startCnt <= startCnt - 8'h1;
        else if (syncCnt + 8'h1 >= txType)
          syncCnt <= 8'h0; // [RULE7]
        else
          syncCnt <= syncCnt + 8'h1;
      end
      if (grant)
        lastSent <= value;
    end
  end

  // ----------------------------------------
  // Inhibit and event timers
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inhCnt <= 16'h0;
      evtCnt <= 16'h0;
    end else if (grant) begin
      inhCnt <= inhibit; // [RULE21] [RULE6]
      evtCnt <= eventTmr; // [RULE21] [RULE5]
    end else begin
      if (tick && inhCnt != 16'h0)
        inhCnt <= inhCnt - 16'h1;
      if (cfgWr || opRise)
        evtCnt <= eventTmr;
      else if (tick && evtCnt != 16'h0)
        evtCnt <= evtCnt - 16'h1;
    end
  end

endmodule

`default_nettype wire

/* ctp_scheduler.v */
// Transmit process-data scheduler with register port and remote setup sequencer
//
// Behaviour
// [RULE1] Payload is chosen register's full 32 bits
// [RULE2] Default transmission type is 255, asynchronous
// [RULE3] Send once on entering operational or configuring; the code does this for types 254-255 only
// [RULE4] Send when mapped value differs from last
// [RULE5] Refresh after 200 ms without a frame
// [RULE6] At least 2 ms between frames by default
// [RULE7] Types 1-240 every N SYNCs; 0 on change
// [RULE8] Inhibit sets least gap; zero means none
// [RULE9] Event timer sets longest gap; zero disables
// [RULE10] Sync mode holds timer and change sends
// [RULE11] Skip starting SYNC count before first send
// [RULE12] Identifier: node in low 7, channel above
// [RULE13] Bases 180h and 280h plus node
// [RULE14] Bases 380h and 480h plus node
// [RULE15] Channels one to four; lower wins
// [RULE16] Setup objects 1800h-1803h and 1A00h-1A03h
// [RULE17] No frames before operational state
// [RULE18] Consumers ignore frames until operational
// [RULE19] One SYNC producer, bit 30, period in us
// [RULE20] Remote setup repeats whole sequence on failure
// [RULE21] Each frame restarts event and inhibit timers
//
// Decided for this implementation: the address map and the plain strobed port.
`include "ctp_consts.vh"
`default_nettype none

module ctp_scheduler #(
  parameter SDO_TO_CYC = `CTP_SDO_TO_CYC,
  parameter DATA_WORDS = 16
) (
  input wire sys_clk, // System clock
  input wire rst, // Async reset, active high
  input wire [7:0] addr, // Register address
  input wire [31:0] wrData, // Write data
  input wire wrEn, // Write strobe
  input wire rdEn, // Read strobe
  output reg [31:0] rdData, // Read data, next cycle
  input wire nmtOperational, // Node in operational state
  input wire syncIn, // SYNC frame received
  output reg txValid, // Frame offered
  output reg [10:0] txId, // Frame identifier
  output reg [31:0] txData, // Frame payload
  input wire txReady, // Controller takes frame
  output reg sdoReq, // Dictionary write request
  output reg [15:0] sdoIndex, // Object index
  output reg [7:0] sdoSub, // Object subindex
  output reg [31:0] sdoData, // Object value
  input wire sdoDone, // Write acknowledged
  input wire sdoFail // Write aborted
);

  localparam S_IDLE = 2'h0;
  localparam S_LOAD = 2'h1;
  localparam S_WAIT = 2'h2;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [10:0] cobId;
    input [1:0] ch;
    input [6:0] node;
    begin
      cobId = {`CTP_ID_BASE_LSB + {1'b0, ch, 1'b0}, node}; // [RULE12] [RULE13] [RULE14]
    end
  endfunction

  function [1:0] lowestDue;
    input [3:0] vec;
    begin
      if (vec[0])
        lowestDue = 2'h0;
      else if (vec[1])
        lowestDue = 2'h1;
      else if (vec[2])
        lowestDue = 2'h2;
      else
        lowestDue = 2'h3;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] dataMem [0:DATA_WORDS-1];
  reg [7:0] cfgType [0:3];
  reg [7:0] cfgStart [0:3];
  reg [3:0] cfgReg [0:3];
  reg [3:0] cfgEn;
  reg [15:0] cfgInh [0:3];
  reg [15:0] cfgEvt [0:3];
  reg [3:0] cfgWr;
  reg [3:0] grantVec;
  reg [6:0] nodeId;
  reg [11:0] tickCnt;
  reg tick;
  reg [31:0] sdoArg0;
  reg [31:0] sdoArg1;
  reg [1:0] sdoState;
  reg [2:0] sdoStep;
  reg [31:0] sdoTimer;
  reg [7:0] sdoRetries;
  reg [15:0] stepIndex;
  reg [7:0] stepSub;
  reg [31:0] stepData;
  wire [3:0] dueVec;
  wire [127:0] lastVec;
  wire [1:0] pick = lowestDue(dueVec);
  wire [1:0] wrCh = addr[3:2];
  wire chSel = addr[7:4] == `CTP_A_CH_BASE >> 4;
  wire dataSel = addr[7:4] == `CTP_A_DATA_BASE >> 4;
  wire [1:0] sdoCh = sdoArg0[25:24];
  integer i;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tickCnt <= 12'h0;
      tick <= 1'b0;
    end else if (tickCnt == `CTP_TICK_CYC - 1) begin
      tickCnt <= 12'h0;
      tick <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 12'h1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      ctp_channel u_ch (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .syncIn(syncIn),
        .oper(nmtOperational),
        .enable(cfgEn[g]),
        .cfgWr(cfgWr[g]),
        .grant(grantVec[g]),
        .txType(cfgType[g]),
        .startSync(cfgStart[g]),
        .inhibit(cfgInh[g]),
        .eventTmr(cfgEvt[g]),
        .value(dataMem[cfgReg[g]]), // [RULE1]
        .due(dueVec[g]),
        .lastSent(lastVec[g*32 +: 32])
      );
    end
  endgenerate

  // ----------------------------------------
  // Frame output
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txId <= 11'h0;
      txData <= 32'h0;
      grantVec <= 4'h0;
    end else begin
      grantVec <= 4'h0;
      if (txValid) begin
        if (txReady)
          txValid <= 1'b0;
      end else if (dueVec != 4'h0 && grantVec == 4'h0) begin
        txValid <= 1'b1;
        txId <= cobId(pick, nodeId); // [RULE15]
        txData <= dataMem[cfgReg[pick]]; // [RULE1]
        grantVec[pick] <= 1'b1; // [RULE21]
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nodeId <= `CTP_NODE_DEF;
      cfgEn <= 4'h0;
      cfgWr <= 4'h0;
      sdoArg0 <= {8'h0, 8'h0, 8'h0, `CTP_TYPE_DEF};
      sdoArg1 <= {`CTP_EVENT_DEF, `CTP_INHIBIT_DEF};
      for (i = 0; i < 4; i = i + 1) begin
        cfgType[i] <= `CTP_TYPE_DEF; // [RULE2]
        cfgStart[i] <= 8'h0;
        cfgReg[i] <= 4'h0;
        cfgInh[i] <= `CTP_INHIBIT_DEF; // [RULE6]
        cfgEvt[i] <= `CTP_EVENT_DEF; // [RULE5]
      end
      for (i = 0; i < DATA_WORDS; i = i + 1)
        dataMem[i] <= 32'h0;
    end else begin
      cfgWr <= 4'h0;
      if (wrEn) begin
        if (addr == `CTP_A_NODE)
          nodeId <= wrData[6:0];
        if (addr == `CTP_A_SDO_ARG0)
          sdoArg0 <= wrData;
        if (addr == `CTP_A_SDO_ARG1)
          sdoArg1 <= wrData;
        if (dataSel && addr[3:0] < DATA_WORDS)
          dataMem[addr[3:0]] <= wrData;
        if (chSel) begin
          case (addr[1:0])
            `CTP_CH_CFG: begin
              cfgType[wrCh] <= wrData[7:0];
              cfgStart[wrCh] <= wrData[15:8];
              cfgReg[wrCh] <= wrData[19:16];
              cfgEn[wrCh] <= wrData[`CTP_CFG_EN_BIT];
              cfgWr[wrCh] <= 1'b1; // [RULE3]
            end
            `CTP_CH_INH: cfgInh[wrCh] <= wrData[15:0]; // [RULE8]
            `CTP_CH_EVT: cfgEvt[wrCh] <= wrData[15:0]; // [RULE9]
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData <= 32'h0;
    end else if (rdEn) begin
      rdData <= 32'h0;
      if (addr == `CTP_A_NODE)
        rdData <= {25'h0, nodeId};
      if (addr == `CTP_A_STATUS)
        rdData <= {16'h0, sdoRetries, 1'b0, sdoState != S_IDLE, txValid, nmtOperational, dueVec};
      if (addr == `CTP_A_SDO_ARG0)
        rdData <= sdoArg0;
      if (addr == `CTP_A_SDO_ARG1)
        rdData <= sdoArg1;
      if (addr == `CTP_A_SDO_GO)
        rdData <= {27'h0, sdoStep, sdoState};
      if (dataSel && addr[3:0] < DATA_WORDS)
        rdData <= dataMem[addr[3:0]];
      if (chSel) begin
        case (addr[1:0])
          `CTP_CH_CFG: rdData <= {7'h0, cfgEn[wrCh], 4'h0, cfgReg[wrCh], cfgStart[wrCh], cfgType[wrCh]};
          `CTP_CH_INH: rdData <= {16'h0, cfgInh[wrCh]};
          `CTP_CH_EVT: rdData <= {16'h0, cfgEvt[wrCh]};
          default: rdData <= lastVec[wrCh*32 +: 32];
        endcase
      end
    end
  end

  // ----------------------------------------
  // Remote setup steps
  // ----------------------------------------
  always @* begin
    stepIndex = `CTP_OBJ_MAP + {14'h0, sdoCh}; // [RULE16]
    stepSub = 8'h0;
    stepData = 32'h0;
    case (sdoStep)
      3'h0: begin
        stepIndex = `CTP_OBJ_COMM + {14'h0, sdoCh}; // [RULE16]
        stepSub = `CTP_SUB_TYPE;
        stepData = {24'h0, sdoArg0[7:0]};
      end
      3'h1: begin
        stepIndex = `CTP_OBJ_COMM + {14'h0, sdoCh};
        stepSub = `CTP_SUB_INH;
        stepData = {16'h0, sdoArg1[15:0]};
      end
      3'h2: begin
        stepIndex = `CTP_OBJ_COMM + {14'h0, sdoCh};
        stepSub = `CTP_SUB_EVT;
        stepData = {16'h0, sdoArg1[31:16]};
      end
      3'h3: begin
        stepIndex = `CTP_OBJ_COMM + {14'h0, sdoCh};
        stepSub = `CTP_SUB_START;
        stepData = {24'h0, sdoArg0[15:8]};
      end
      3'h5: begin
        stepSub = 8'h01;
        stepData = {`CTP_OBJ_USER + {8'h0, sdoArg0[23:16]}, 8'h0, `CTP_MAP_BITS};
      end
      3'h6: stepData = 32'h1;
      default: ;
    endcase
  end

  // ----------------------------------------
  // Remote setup sequencer
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdoState <= S_IDLE;
      sdoStep <= 3'h0;
      sdoTimer <= 32'h0;
      sdoRetries <= 8'h0;
      sdoReq <= 1'b0;
      sdoIndex <= 16'h0;
      sdoSub <= 8'h0;
      sdoData <= 32'h0;
    end else begin
      case (sdoState)
        S_IDLE: begin
          if (wrEn && addr == `CTP_A_SDO_GO) begin
            sdoStep <= 3'h0;
            sdoRetries <= 8'h0;
            sdoState <= S_LOAD;
          end
        end
        S_LOAD: begin
          sdoIndex <= stepIndex;
          sdoSub <= stepSub;
          sdoData <= stepData;
          sdoReq <= 1'b1;
          sdoTimer <= 32'h0;
          sdoState <= S_WAIT;
        end
        S_WAIT: begin
          sdoTimer <= sdoTimer + 32'h1;
          if (sdoFail || sdoTimer == SDO_TO_CYC - 1) begin
            sdoReq <= 1'b0;
            sdoStep <= 3'h0; // [RULE20]
            sdoRetries <= sdoRetries + 8'h1;
            sdoState <= S_LOAD;
          end else if (sdoDone) begin
            sdoReq <= 1'b0;
            if (sdoStep == `CTP_SDO_STEPS - 3'h1) begin
              sdoState <= S_IDLE;
            end else begin
              sdoStep <= sdoStep + 3'h1;
              sdoState <= S_LOAD;
            end
          end
        end
        default: sdoState <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* ctp_scheduler_properties.sv */
// Port checker for the transmit scheduler
`default_nettype none

module ctp_sched_checker #(
  parameter SDO_TO_CYC = 200,
  parameter DATA_WORDS = 16
) (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic nmtOperational, // operational
  input wire logic txValid, // frame offered
  input wire logic [10:0] txId, // identifier
  input wire logic [31:0] txData, // payload
  input wire logic txReady, // frame taken
  input wire logic sdoReq, // setup request
  input wire logic [15:0] sdoIndex, // object
  input wire logic [7:0] sdoSub, // subindex
  input wire logic [31:0] sdoData, // value
  input wire logic sdoDone, // acknowledged
  input wire logic sdoFail // aborted
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Frame link
  // ----------------------------------------
  property p_frameHold;
    txValid && !txReady |=> txValid && $stable(txId) && $stable(txData);
  endproperty
  a_frameHold: assert property (p_frameHold)
    else $error("frame changed before taken");
  property p_frameGap;
    txValid && txReady |=> !txValid;
  endproperty
  a_frameGap: assert property (p_frameGap)
    else $error("no idle cycle after frame");
  property p_onlyOper;
    $rose(txValid) |-> $past(nmtOperational);
  endproperty
  a_onlyOper: assert property (p_onlyOper)
    else $error("frame offered while not operational");
  property p_idShape;
    txValid |-> txId[10:7] inside {4'h3, 4'h5, 4'h7, 4'h9};
  endproperty
  a_idShape: assert property (p_idShape)
    else $error("identifier base wrong");
  property p_takenOnly;
    $fell(txValid) |-> $past(txReady);
  endproperty
  a_takenOnly: assert property (p_takenOnly)
    else $error("frame withdrawn untaken");

  // ----------------------------------------
  // Remote setup link
  // ----------------------------------------
  property p_sdoHold;
    sdoReq && $past(sdoReq) |-> $stable(sdoIndex) && $stable(sdoSub) && $stable(sdoData);
  endproperty
  a_sdoHold: assert property (p_sdoHold)
    else $error("setup request changed");
  property p_sdoEnd;
    sdoReq && (sdoDone || sdoFail) |=> !sdoReq;
  endproperty
  a_sdoEnd: assert property (p_sdoEnd)
    else $error("setup request not ended");
  property p_sdoObj;
    sdoReq |-> sdoIndex inside {[16'h1800:16'h1803], [16'h1a00:16'h1a03]};
  endproperty
  a_sdoObj: assert property (p_sdoObj)
    else $error("setup object out of range");
  property p_sdoRetry;
    sdoReq && sdoFail |-> ##[2:8] ($rose(sdoReq) && sdoSub == 8'h02 && sdoIndex[15:8] == 8'h18);
  endproperty
  a_sdoRetry: assert property (p_sdoRetry)
    else $error("sequence not restarted");

  c_frame: cover property (txValid && txReady);
  c_fail: cover property (sdoReq && sdoFail);
  c_done: cover property (sdoReq && sdoDone);
endmodule

bind ctp_scheduler ctp_sched_checker #(.SDO_TO_CYC(SDO_TO_CYC), .DATA_WORDS(DATA_WORDS)) ctp_sched_checker_i (
  .sys_clk(sys_clk), .rst(rst), .nmtOperational(nmtOperational), .txValid(txValid), .txId(txId),
  .txData(txData), .txReady(txReady), .sdoReq(sdoReq), .sdoIndex(sdoIndex), .sdoSub(sdoSub),
  .sdoData(sdoData), .sdoDone(sdoDone), .sdoFail(sdoFail));

`default_nettype wire

/* ctp_bus_partner.sv */
// Far side model: frame sink and remote setup responder
`default_nettype none

module ctp_bus_partner (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic txValid, // frame offered
  input wire logic sdoReq, // setup request
  input wire logic slow, // stall frames
  input wire logic failArm, // abort one step
  output logic txReady, // frame taken
  output logic sdoDone, // acknowledged
  output logic sdoFail // aborted
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] waitCnt;
  logic [1:0] sdoCnt;
  logic failUsed;
  wire logic failNow = failArm && !failUsed;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 5'h00;
      txReady <= 1'b0;
      sdoCnt <= 2'h0;
      sdoDone <= 1'b0;
      sdoFail <= 1'b0;
      failUsed <= 1'b0;
    end else begin
      waitCnt <= (txValid && !txReady) ? waitCnt + 5'h01 : 5'h00;
      txReady <= txValid && !txReady && waitCnt >= (slow ? 5'h13 : 5'h00);
      sdoCnt <= sdoReq ? sdoCnt + 2'h1 : 2'h0;
      sdoDone <= sdoReq && sdoCnt == 2'h2 && !failNow;
      sdoFail <= sdoReq && sdoCnt == 2'h2 && failNow;
      if (sdoFail) begin
        failUsed <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* test_can_tx_pdo_scheduler.sv */
// Testbench for the transmit scheduler
`default_nettype none

module test_can_tx_pdo_scheduler;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst = 1, wrEn = 0, rdEn = 0, nmtOperational = 0, syncIn = 0, slow = 0, failArm = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h00000000;
  wire logic [31:0] rdData, txData, sdoData;
  wire logic [10:0] txId;
  wire logic [15:0] sdoIndex;
  wire logic [7:0] sdoSub;
  wire logic txValid, txReady, sdoReq, sdoDone, sdoFail;
  int mismatches = 0, samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  ctp_scheduler #(.SDO_TO_CYC(200)) ctp_scheduler_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .nmtOperational(nmtOperational),
    .syncIn(syncIn), .txValid(txValid), .txId(txId), .txData(txData), .txReady(txReady),
    .sdoReq(sdoReq), .sdoIndex(sdoIndex), .sdoSub(sdoSub), .sdoData(sdoData), .sdoDone(sdoDone),
    .sdoFail(sdoFail));
  ctp_bus_partner ctp_bus_partner_i (.sys_clk(sys_clk), .rst(rst), .txValid(txValid), .sdoReq(sdoReq),
    .slow(slow), .failArm(failArm), .txReady(txReady), .sdoDone(sdoDone), .sdoFail(sdoFail));

  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [55:0] e, input logic [55:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // ----------------------------------------
  // Bus and link tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1;
    @(posedge sys_clk);
    wrEn <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rdEn <= 1;
    @(posedge sys_clk);
    rdEn <= 0;
    #1 chk("rdData", e, rdData);
  endtask

  task automatic pulseSync;
    @(posedge sys_clk);
    syncIn <= 1;
    @(posedge sys_clk);
    syncIn <= 0;
  endtask

  task automatic noFrame(input int n);
    logic hit;
    hit = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (txValid !== 1'b0) hit = 1;
    end
    chk("noFrame", 0, hit);
  endtask

  task automatic getFrame(input logic [10:0] id, input logic [31:0] d, input int n);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (!(txValid === 1'b1 && txReady === 1'b1) && k < n);
    chk("frameSeen", 1, txValid === 1'b1 && txReady === 1'b1);
    chk("txId", id, txId);
    chk("txData", d, txData);
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(8'h00, 32'h1);
    rd(8'h10, 32'hff);
    rd(8'h11, 32'd20);
    rd(8'h12, 32'd2000);
    rd(8'h08, 32'h0);
  endtask

  task automatic t_async;
    wr(8'h40, 32'h12345678);
    wr(8'h11, 32'h2);
    wr(8'h12, 32'h6);
    wr(8'h10, 32'h010000ff);
    noFrame(3000);
    @(posedge sys_clk);
    nmtOperational <= 1;
    getFrame(11'h181, 32'h12345678, 100);
    wr(8'h40, 32'hcafef00d);
    noFrame(2400);
    getFrame(11'h181, 32'hcafef00d, 5200);
    noFrame(12400);
    getFrame(11'h181, 32'hcafef00d, 5200);
  endtask

  task automatic t_ids;
    wr(8'h00, 32'h5);
    slow <= 1;
    wr(8'h1c, 32'h010100ff);
    wr(8'h18, 32'h010100ff);
    wr(8'h14, 32'h010100ff);
    getFrame(11'h485, 32'h0, 200);
    getFrame(11'h285, 32'h0, 200);
    getFrame(11'h385, 32'h0, 200);
    slow <= 0;
  endtask

  task automatic t_sync;
    logic [5:0] pat;
    logic hit;
    wr(8'h11, 32'h0);
    wr(8'h12, 32'h0);
    wr(8'h10, 32'h01000102);
    // Let the inhibit run by the last refresh expire
    noFrame(5100);
    for (int i = 0; i < 6; i++) begin
      pulseSync;
      hit = 0;
      repeat (40) @(negedge sys_clk) if (txValid === 1'b1) hit = 1;
      pat[i] = hit;
    end
    chk("syncPattern", 6'b010100, pat);
    wr(8'h10, 32'h01000000);
    wr(8'h40, 32'h0badcafe);
    noFrame(300);
    pulseSync;
    getFrame(11'h185, 32'h0badcafe, 40);
    pulseSync;
    noFrame(60);
  endtask

  task automatic t_sdo;
    logic [55:0] exp [8];
    int k;
    exp = '{{16'h1801, 8'h02, 32'hff}, {16'h1801, 8'h02, 32'hff}, {16'h1801, 8'h03, 32'h14},
      {16'h1801, 8'h05, 32'h7d0}, {16'h1801, 8'h06, 32'h0}, {16'h1a01, 8'h00, 32'h0},
      {16'h1a01, 8'h01, 32'h20030020}, {16'h1a01, 8'h00, 32'h1}};
    wr(8'h02, 32'h010300ff);
    failArm <= 1;
    wr(8'h03, 32'h07d00014);
    wr(8'h04, 32'h0);
    for (int i = 0; i < 8; i++) begin
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (sdoReq !== 1'b1 && k < 100);
      chk("sdoStep", exp[i], {sdoIndex, sdoSub, sdoData});
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (sdoReq !== 1'b0 && k < 100);
    end
    rd(8'h04, 32'h18);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    t_reset;
    t_async;
    t_ids;
    t_sync;
    t_sdo;
    conclude;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    conclude;
  end
endmodule

`default_nettype wire
